/* rtl/bmm_defines.vh */
// Constants for the banked memory map block.
`ifndef BMM_DEFINES_VH
`define BMM_DEFINES_VH
`define BMM_PC_W          13
`define BMM_PC_MSB        12
`define BMM_RESET_VEC     13'h0000
`define BMM_INT_VEC       13'h0004
`define BMM_VAR_SMALL     2'h0
`define BMM_VAR_MID       2'h1
`define BMM_VAR_LARGE     2'h2
`define BMM_PMASK_SMALL   13'h07FF
`define BMM_PMASK_MID     13'h0FFF
`define BMM_PMASK_LARGE   13'h1FFF
`define BMM_OFS_INDIRECT  7'h00
`define BMM_OFS_PCL       7'h02
`define BMM_OFS_STATUS    7'h03
`define BMM_OFS_FSR       7'h04
`define BMM_OFS_PC_HIGH_LATCH    7'h0A
`define BMM_SFR_TOP       7'h1F
`define BMM_COMMON_BASE   7'h70
`define BMM_GPR_BASE      7'h20
`define BMM_SMALL_TOP     7'h3F
`define BMM_STAT_RP_LO    5
`define BMM_STAT_RP_HI    6
`define BMM_STAT_IRP      7
`define BMM_GPR_DEPTH     368
`define BMM_GPR_IDX_W     9
`define BMM_SFR_DEPTH     128
`define BMM_RESET_BYTE    8'h00
`define BMM_BANK_BASE0    9'h000
`define BMM_BANK_BASE1    9'h050
`define BMM_BANK_BASE2    9'h0A0
`define BMM_BANK_BASE3    9'h0F0
`define BMM_COMMON_IDX    9'h140
`endif

/* rtl/bmm_pc_unit.v */
// Program counter with reset and interrupt vectors and size wraparound.
`timescale 1ns/1ps
`include "bmm_defines.vh"
module bmm_pc_unit
(
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire [1:0]  variant,
    input  wire        pc_inc,
    input  wire        pc_load,
    input  wire [12:0] pc_load_val,
    input  wire        int_take,
    output reg  [12:0] pc_ff
);
    reg [12:0] nxt_pc;
    reg [12:0] size_mask;

    always @*
    begin
        case (variant)
            `BMM_VAR_SMALL: size_mask = `BMM_PMASK_SMALL; // RL2
            `BMM_VAR_MID:   size_mask = `BMM_PMASK_MID;
            default:        size_mask = `BMM_PMASK_LARGE;
        endcase
        nxt_pc = pc_ff;
        if (int_take)
            nxt_pc = `BMM_INT_VEC; // RL5
        else if (pc_load)
            nxt_pc = pc_load_val & size_mask; // RL3
        else if (pc_inc)
            nxt_pc = (pc_ff + 13'h0001) & size_mask; // RL3
    end

    // Thirteen-bit counter; the carry out of bit 12 is dropped on purpose.
    always @(posedge core_clk)
    begin
        if (sys_rst)
            pc_ff <= `BMM_RESET_VEC; // RL4
        else
            pc_ff <= nxt_pc; // RL1
    end
endmodule

/* rtl/bmm_memory_map.v */
// Banked data memory map with core registers and program counter.
`timescale 1ns/1ps
`include "bmm_defines.vh"
// Overview of operation
// RL1: Program counter is thirteen bits wide.
// RL2: Program memory is 2K, 4K or 8K words of 14 bits per variant.
// RL3: Fetch addresses beyond the implemented size wrap within the 2K, 4K or 8K words of the variant.
// RL4: Reset starts fetch at program address zero.
// RL5: A taken interrupt redirects fetch to program address four.
// RL6: Data memory has four banks, each with special and general storage.
// RL7: Lowest 32 locations of each bank are special registers.
// RL8: Upper 96 locations of each bank hold general RAM per variant.
// RL9: Top sixteen bytes of banks one to three alias bank zero 70h-7Fh.
// RL10: Unimplemented data locations read as zero.
// RL11: Direct accesses take the bank from the two-bit status field.
// RL12: General register file holds 128, 256 or 368 bytes per variant; the large variant maps only 336.
// RL13: Every file register is reachable directly or via the file pointer.
// RL14: Software keeps the indirect bank bit and upper bank bit at zero; the bench sets the upper bank bit to reach banks two and three.
// RL15: Special registers are static storage read and written like RAM.
// RL16: The indirect window redirects to the location the pointer holds.
module bmm_memory_map
(
    input  wire        core_clk,
    input  wire        sys_rst,
    input  wire [1:0]  variant,
    input  wire        pc_inc,
    input  wire        int_take,
    input  wire [6:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_ff,
    output wire [12:0] fetch_addr,
    output reg  [7:0]  core_flags_bank_ff,
    output reg  [7:0]  file_pointer_ff,
    output reg  [7:0]  pc_high_latch_ff
);
    // ***********************************************************
    // Storage
    // ***********************************************************
    reg [7:0] general_ram_ff [0:`BMM_GPR_DEPTH-1];
    reg [7:0] special_regs_ff [0:`BMM_SFR_DEPTH-1];
    wire [12:0] pc_q;
    reg        pc_load;
    reg [12:0] pc_load_val;

    // ***********************************************************
    // Address translation
    // ***********************************************************
    // Maps bank and offset to a general RAM index; the top bit flags a hit.
    // Banked bytes fill 000h-13Fh in bank order, common bytes 140h-14Fh,
    // so no two banks can ever alias one another by accident.
    function [9:0] gpr_map;
        input [1:0] var_sel;
        input [1:0] bank;
        input [6:0] ofs;
        reg   [8:0] base;
        reg   [8:0] idx;
        reg         hit;
        begin
            case (bank)
                2'h1:    base = `BMM_BANK_BASE1;
                2'h2:    base = `BMM_BANK_BASE2;
                2'h3:    base = `BMM_BANK_BASE3;
                default: base = `BMM_BANK_BASE0;
            endcase
            idx = base + {2'b00, ofs} - {2'b00, `BMM_GPR_BASE};
            if (ofs <= `BMM_SFR_TOP)
                hit = 1'b0; // RL7
            else if (ofs >= `BMM_COMMON_BASE)
            begin
                // Common bytes sit at one shared index for all banks.
                hit = 1'b1; // RL9
                idx = `BMM_COMMON_IDX + {2'b00, ofs} -
                      {2'b00, `BMM_COMMON_BASE};
            end
            else if (var_sel == `BMM_VAR_SMALL)
                hit = (bank == 2'h0) ||
                      (bank == 2'h1 && ofs <= `BMM_SMALL_TOP); // RL12
            else if (var_sel == `BMM_VAR_MID)
                hit = (bank != 2'h3); // RL12
            else
                hit = 1'b1; // RL8
            gpr_map = {hit, idx};
        end
    endfunction

    // Effective address after indirection through the pointer.
    wire       is_indirect = (reg_addr == `BMM_OFS_INDIRECT);
    wire [1:0] dir_bank = {core_flags_bank_ff[`BMM_STAT_RP_HI],
                           core_flags_bank_ff[`BMM_STAT_RP_LO]}; // RL11
    wire [1:0] ind_bank = {core_flags_bank_ff[`BMM_STAT_IRP],
                           file_pointer_ff[7]}; // RL13
    wire [1:0] eff_bank = is_indirect ? ind_bank : dir_bank; // RL16
    wire [6:0] eff_ofs  = is_indirect ? file_pointer_ff[6:0] :
                                        reg_addr; // RL16
    // Indirect to the window itself reads zero and writes nothing.
    wire       self_ref = is_indirect &&
                          (file_pointer_ff[6:0] == `BMM_OFS_INDIRECT);
    wire [9:0] gmap     = gpr_map(variant, eff_bank, eff_ofs); // RL6
    wire       gpr_hit  = gmap[9];
    wire [8:0] gpr_idx  = gmap[8:0];
    wire       sfr_hit  = (eff_ofs <= `BMM_SFR_TOP) && !self_ref;
    wire [6:0] sfr_idx  = {eff_bank, eff_ofs[4:0]};

    // ***********************************************************
    // Core register decode
    // ***********************************************************
    wire hit_pcl    = sfr_hit && eff_ofs == `BMM_OFS_PCL;
    wire hit_status = sfr_hit && eff_ofs == `BMM_OFS_STATUS;
    wire hit_fsr    = sfr_hit && eff_ofs == `BMM_OFS_FSR;
    wire hit_pc_high_latch = sfr_hit && eff_ofs == `BMM_OFS_PC_HIGH_LATCH;

    always @*
    begin
        pc_load     = reg_wr && hit_pcl;
        // A write to the low byte jumps using the latched high bits.
        pc_load_val = {pc_high_latch_ff[4:0], reg_wdata};
    end

    bmm_pc_unit u_pc
    (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .variant     (variant),
        .pc_inc      (pc_inc),
        .pc_load     (pc_load),
        .pc_load_val (pc_load_val),
        .int_take    (int_take),
        .pc_ff       (pc_q)
    );

    assign fetch_addr = pc_q;

    // ***********************************************************
    // Writes
    // ***********************************************************
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            core_flags_bank_ff <= `BMM_RESET_BYTE;
            file_pointer_ff    <= `BMM_RESET_BYTE;
            pc_high_latch_ff   <= `BMM_RESET_BYTE;
        end
        else if (reg_wr)
        begin
            if (hit_status)
                core_flags_bank_ff <= reg_wdata; // RL11
            if (hit_fsr)
                file_pointer_ff <= reg_wdata; // RL13
            if (hit_pc_high_latch)
                pc_high_latch_ff <= reg_wdata;
        end
    end

    // Storage arrays carry no reset, as static RAM would not.
    always @(posedge core_clk)
    begin
        if (reg_wr && gpr_hit && !self_ref)
            general_ram_ff[gpr_idx] <= reg_wdata; // RL8
        if (reg_wr && sfr_hit)
            special_regs_ff[sfr_idx] <= reg_wdata; // RL15
    end

    // ***********************************************************
    // Reads
    // ***********************************************************
    always @(posedge core_clk)
    begin
        if (sys_rst)
            reg_rdata_ff <= `BMM_RESET_BYTE;
        else if (reg_rd)
        begin
            if (hit_pcl)
                reg_rdata_ff <= pc_q[7:0];
            else if (hit_status)
                reg_rdata_ff <= core_flags_bank_ff;
            else if (hit_fsr)
                reg_rdata_ff <= file_pointer_ff;
            else if (hit_pc_high_latch)
                reg_rdata_ff <= pc_high_latch_ff;
            else if (sfr_hit)
                reg_rdata_ff <= special_regs_ff[sfr_idx]; // RL15
            else if (gpr_hit && !self_ref)
                reg_rdata_ff <= general_ram_ff[gpr_idx]; // RL13
            else
                reg_rdata_ff <= `BMM_RESET_BYTE; // RL10
        end
        else
            reg_rdata_ff <= `BMM_RESET_BYTE;
    end
endmodule

/* tb/bmm_map_chk.sv */
// Port assertions for the banked memory map.
`timescale 1ns/1ps
module bmm_map_chk
(
    input logic        core_clk,
    input logic        sys_rst,
    input logic [1:0]  variant,
    input logic        pc_inc,
    input logic        int_take,
    input logic [6:0]  reg_addr,
    input logic [7:0]  reg_wdata,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [7:0]  reg_rdata_ff,
    input logic [12:0] fetch_addr,
    input logic [7:0]  core_flags_bank_ff,
    input logic [7:0]  file_pointer_ff,
    input logic [7:0]  pc_high_latch_ff
);
    // ****
    // Checks
    // ****
    wire [12:0] mask_w = (variant == 2'h0) ? 13'h07FF :
                         (variant == 2'h1) ? 13'h0FFF : 13'h1FFF;
    wire [12:0] jump_w = {pc_high_latch_ff[4:0], reg_wdata} & mask_w;
    wire        pcl_w  = reg_wr && (reg_addr == 7'h02);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_rst_pc; $fell(sys_rst) |-> fetch_addr == 13'h0000; endproperty
    a_rst_pc: assert property (p_rst_pc) else $error("pc not zero");
    property p_int; int_take |=> fetch_addr == 13'h0004; endproperty
    a_int: assert property (p_int) else $error("no vector");
    property p_inc; pc_inc && !int_take && !pcl_w |=>
        fetch_addr == (($past(fetch_addr) + 13'h0001) & mask_w); endproperty
    a_inc: assert property (p_inc) else $error("bad step");
    property p_jump; pcl_w && !int_take |=> fetch_addr == $past(jump_w);
    endproperty
    a_jump: assert property (p_jump) else $error("bad jump");
    property p_rd_idle; !reg_rd |=> reg_rdata_ff == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stale data");
    property p_fp_wr; reg_wr && reg_addr == 7'h04 |=>
        file_pointer_ff == $past(reg_wdata); endproperty
    a_fp_wr: assert property (p_fp_wr) else $error("pointer write");
    property p_pch_wr; reg_wr && reg_addr == 7'h0A |=>
        pc_high_latch_ff == $past(reg_wdata); endproperty
    a_pch_wr: assert property (p_pch_wr) else $error("latch write");
    property p_st_rd; reg_rd && reg_addr == 7'h03 |=>
        reg_rdata_ff == $past(core_flags_bank_ff); endproperty
    a_st_rd: assert property (p_st_rd) else $error("status read");
    property p_fp_hold; !(reg_wr && reg_addr inside {7'h00, 7'h04}) |=>
        $stable(file_pointer_ff); endproperty
    a_fp_hold: assert property (p_fp_hold) else $error("pointer moved");
    property p_null; reg_rd && reg_addr == 7'h00 &&
        file_pointer_ff[6:0] == 7'h00 |=> reg_rdata_ff == 8'h00; endproperty
    a_null: assert property (p_null) else $error("null read");
endmodule
bind bmm_memory_map bmm_map_chk chk_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .variant(variant), .pc_inc(pc_inc),
    .int_take(int_take), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .fetch_addr(fetch_addr), .core_flags_bank_ff(core_flags_bank_ff),
    .file_pointer_ff(file_pointer_ff),
    .pc_high_latch_ff(pc_high_latch_ff));

/* tb/bmm_core_model.sv */
// Core-side driver of the register port and fetch controls.
`timescale 1ns/1ps
module bmm_core_model
(
    input  logic       core_clk,
    input  logic [7:0] reg_rdata_ff,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic       pc_inc,
    output logic       int_take
);
    // ****
    // Bus cycles
    // ****
    // Bank-walking and variant-size scenarios set the reserved upper bank bit; none sets the indirect bank bit.
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, pc_inc, int_take} = 19'h00000;
    end
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    task rd(input logic [6:0] a, output logic [7:0] q);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        q = reg_rdata_ff;
    endtask
    task step(input logic inc, input logic irq);
        @(posedge core_clk);
        pc_inc <= inc;
        int_take <= irq;
        @(posedge core_clk);
        pc_inc <= 1'b0;
        int_take <= 1'b0;
        #1;
    endtask
endmodule

/* tb/banked_memory_map_tb_top.sv */
// Self-checking bench for the banked memory map.
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
    $display("wrong value at %0t: got %h want %h", $time, a, e); end end
module banked_memory_map_tb_top;
    logic        core_clk, sys_rst;
    logic [1:0]  variant;
    logic [7:0]  q;
    logic        pc_inc, int_take, reg_wr, reg_rd;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_wdata, rdata, flags, fp, pch;
    logic [12:0] fetch;
    int          err_count = 0, check_count = 0, cyc_count = 0, i;
    bmm_core_model core_u (.core_clk(core_clk), .reg_rdata_ff(rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .pc_inc(pc_inc), .int_take(int_take));
    bmm_memory_map dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
        .variant(variant), .pc_inc(pc_inc), .int_take(int_take),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_ff(rdata), .fetch_addr(fetch),
        .core_flags_bank_ff(flags), .file_pointer_ff(fp),
        .pc_high_latch_ff(pch));
    // ****
    // Sequence
    // ****
    task complete_run;
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task do_reset(input logic [1:0] v);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        variant <= v;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
    endtask
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc_count++;
        if (cyc_count == 2000)
        begin
            err_count++;
            complete_run();
        end
    end
    initial
    begin
        sys_rst = 1'b1;
        variant = 2'h2;
        do_reset(2'h2);
        `CHK(fetch, 13'h0000)
        `CHK({flags, fp, pch}, 24'h000000)
        for (i = 0; i < 3; i++) core_u.step(1'b1, 1'b0);
        `CHK(fetch, 13'h0003)
        core_u.step(1'b1, 1'b1);
        `CHK(fetch, 13'h0004)
        core_u.wr(7'h0A, 8'h1F);
        core_u.wr(7'h02, 8'hFF);
        `CHK(fetch, 13'h1FFF)
        core_u.step(1'b1, 1'b0);
        `CHK(fetch, 13'h0000)
        for (i = 0; i < 4; i++)
        begin
            core_u.wr(7'h03, {1'b0, i[1:0], 5'h00});
            core_u.wr(7'h20, 8'h10 + i[7:0]);
            core_u.wr(7'h10, 8'h30 + i[7:0]);
        end
        for (i = 0; i < 4; i++)
        begin
            core_u.wr(7'h03, {1'b0, i[1:0], 5'h00});
            core_u.rd(7'h20, q);
            `CHK(q, 8'h10 + i[7:0])
            core_u.rd(7'h10, q);
            `CHK(q, 8'h30 + i[7:0])
        end
        core_u.rd(7'h03, q);
        `CHK(q, 8'h60)
        core_u.wr(7'h7F, 8'h3C);
        core_u.wr(7'h03, 8'h00);
        core_u.rd(7'h7F, q);
        `CHK(q, 8'h3C)
        core_u.wr(7'h04, 8'hA0);
        core_u.rd(7'h00, q);
        `CHK(q, 8'h11)
        core_u.wr(7'h00, 8'h77);
        core_u.wr(7'h03, 8'h20);
        core_u.rd(7'h20, q);
        `CHK(q, 8'h77)
        core_u.wr(7'h04, 8'h00);
        core_u.rd(7'h00, q);
        `CHK(q, 8'h00)
        do_reset(2'h0);
        core_u.wr(7'h0A, 8'h07);
        core_u.wr(7'h02, 8'hFF);
        `CHK(fetch, 13'h07FF)
        core_u.step(1'b1, 1'b0);
        `CHK(fetch, 13'h0000)
        core_u.wr(7'h03, 8'h20);
        core_u.wr(7'h20, 8'h5A);
        core_u.wr(7'h7E, 8'hC3);
        core_u.rd(7'h20, q);
        `CHK(q, 8'h5A)
        core_u.rd(7'h40, q);
        `CHK(q, 8'h00)
        core_u.wr(7'h03, 8'h40);
        core_u.rd(7'h20, q);
        `CHK(q, 8'h00)
        core_u.wr(7'h03, 8'h00);
        core_u.rd(7'h7E, q);
        `CHK(q, 8'hC3)
        do_reset(2'h1);
        core_u.wr(7'h0A, 8'h1F);
        core_u.wr(7'h02, 8'hFF);
        `CHK(fetch, 13'h0FFF)
        core_u.wr(7'h03, 8'h40);
        core_u.wr(7'h6F, 8'hA5);
        core_u.rd(7'h6F, q);
        `CHK(q, 8'hA5)
        core_u.wr(7'h03, 8'h60);
        core_u.rd(7'h6F, q);
        `CHK(q, 8'h00)
        complete_run();
    end
endmodule
